// file: verilog/app_session_cfg.svh
// Constants for the application session and channel manager
// Assumes an APDU front end that parses headers and runs the file system
`ifndef APP_SESSION_CFG_SVH
`define APP_SESSION_CFG_SVH
`define NUM_CHAN 4
`define CURRENT_APP_FID 16'h7fff
`define ROOT_FID 16'h3f00
`define NAME_MAX_LEN 5'h10
`define P1_BY_NAME 8'h04
`define CLA_LEGACY 8'ha0
`define CLA_BASIC 8'h00
`define NO_FILE 16'h0000
`define NO_APP 4'h0
`define SW_OK 16'h9000
`define SW_CLA_UNSUPPORTED 16'h6e00
`define SW_P1P2_UNSUPPORTED 16'h6a86
`define SW_NOT_ALLOWED 16'h6986
`define SW_NOT_FOUND 16'h6a82
`define SW_WRONG_LEN 16'h6700
`define SW_NO_CHANNEL 16'h6881
`define P2_FIRST 2'h0
`define P2_LAST 2'h1
`define P2_NEXT 2'h2
`define P2_PREV 2'h3
`define P2_CLOSE_BIT 6
`endif

// file: verilog/app_session_pkg.sv
// Types for the application session and channel manager
// Used with app_session_cfg.svh
package app_session_pkg;
   typedef enum logic [2:0] {
      CMD_SELECT_NAME, CMD_SELECT_FID, CMD_SELECT_FILE, CMD_MANAGE_OPEN,
      CMD_MANAGE_CLOSE, CMD_OTHER, CMD_RECORD
   } cmd_t;
   typedef enum logic [1:0] {APP_PLAIN, APP_LEGACY, APP_NEWER} app_kind_t;
   typedef struct packed {
      logic [15:0] curDir;
      logic [15:0] curFile;
      logic [3:0] activeApp;
      logic [7:0] recordPtr;
      logic open;
   } chan_t;
endpackage

// file: verilog/app_session_channel_manager.sv
// Session and logical channel bookkeeping of the card command path
// Expects one command at a time from a front end that has already
// matched the application name against an application table (appMatch)
// Function
// - 7FFF resolves to channel's active application directory
// - Full names 1 to 16 bytes, unique
// - P1 04 selects by prefix, P2 chooses
// - Last picks most recent match, across sessions
// - Partial-name selection supported
// - One active session per logical channel
// - Other select, close option, channel close end session
// - Card reset ends every session
// - Reselect active app with activate restarts it
// - Newer session active rejects class A0 with 6E00
// - Active newer session blocks legacy; of legacy apps, only the last-selected one blocks newer
// - Three extra channels; channel 0 always open
// - Card assigns channel numbers, advertises maximum
// - No interleaving of commands across channels
// - Shared access only to shareable files
// - Separate record pointer per channel
// - Open returns card-chosen channel number
// - Channel open until closed or card deactivated
// - Open from basic: root, no application, no file
// - Open from other channel inherits directory and application
// - Directory and file tracked per channel
// - Open on unshareable directory refused, not allowed
// - Root directory selected after reset
`timescale 1ns/1ps
`include "app_session_cfg.svh"
module app_session_channel_manager
   import app_session_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cmdValid,
   input wire cmd_t cmdKind,
   input wire logic [7:0] cmdCla,
   input wire logic [1:0] cmdChan,
   input wire logic [7:0] cmdP1,
   input wire logic [7:0] cmdP2,
   input wire logic [4:0] nameLen,
   input wire logic [15:0] cmdFid,
   input wire logic [15:0] fileParent,
   input wire logic fileIsDir,
   input wire logic fileShareable,
   input wire logic [7:0] recordValue,
   input wire logic [14:0] appMatch,
   input wire app_kind_t appKind,
   input wire logic [15:0] appDirFid,
   output logic cmdReady,
   output logic rspValid,
   output logic [15:0] rspStatus,
   output logic [1:0] rspChan,
   output logic [3:0] rspApp,
   output logic [15:0] rspDir,
   output logic [15:0] rspFile,
   output logic [7:0] rspRecord,
   output logic appStart,
   output logic appStop,
   output logic [3:0] maxChannels
);
   typedef struct packed {
      chan_t [`NUM_CHAN-1:0] chan;
      logic [15:0][15:0] appDir;
      logic [15:0][3:0] recency;
      logic [15:0] appBusy;
      logic legacyOn;
      logic newerOn;
      logic [3:0] newerApp;
      logic [3:0] legacyApp;
      logic busy;
      logic rspValid;
      logic [15:0] rspStatus;
      logic [1:0] rspChan;
      logic [3:0] rspApp;
      logic [15:0] rspDir;
      logic [15:0] rspFile;
      logic [7:0] rspRecord;
      logic appStart;
      logic appStop;
   } state_t;

   state_t s_q, s_d;

   // Pick by P2 among matching application indexes; 0 means none
   // Ties in recency go to the higher index
   function automatic logic [3:0] pickApp(input logic [14:0] m, input logic [1:0] how,
         input logic [3:0] cur, input logic [15:0][3:0] rec);
      logic [3:0] r;
      logic [3:0] best;
      r = `NO_APP;
      best = 4'h0;
      for (int i = 1; i < 16; i++) begin
         if (m[i-1]) begin
            unique case (how)
               `P2_FIRST: if (r == `NO_APP) r = 4'(i);
               `P2_NEXT: if (r == `NO_APP && 4'(i) > cur) r = 4'(i);
               `P2_PREV: if (4'(i) < cur) r = 4'(i);
               `P2_LAST: if (rec[i] >= best) begin
                  r = 4'(i);
                  best = rec[i];
               end
            endcase
         end
      end
      return r;
   endfunction

   // End a session on one channel and drop the kind flags it held
   function automatic state_t endSession(input state_t s, input logic [1:0] c);
      state_t t;
      logic [3:0] a;
      t = s;
      a = s.chan[c].activeApp;
      if (a != `NO_APP) begin
         t.chan[c].activeApp = `NO_APP;
         t.appStop = 1'b1;
         t.appBusy[a] = 1'b0;
         for (int k = 0; k < `NUM_CHAN; k++)
            if (k != c && s.chan[k].activeApp == a) t.appBusy[a] = 1'b1;
         if (!t.appBusy[a] && s.newerApp == a) begin
            t.newerOn = 1'b0;
            t.newerApp = `NO_APP;
         end
         // A legacy session shared with another channel keeps its claim
         if (!t.appBusy[a] && s.legacyApp == a) begin
            t.legacyOn = 1'b0;
            t.legacyApp = `NO_APP;
         end
      end
      return t;
   endfunction

   always_comb begin
      logic [3:0] pick;
      logic [1:0] c;
      logic [1:0] freeCh;
      logic found;
      pick = `NO_APP;
      freeCh = 2'h0;
      found = 1'b0;
      c = cmdChan;
      s_d = s_q;
      s_d.rspValid = 1'b0;
      s_d.appStart = 1'b0;
      s_d.appStop = 1'b0;
      s_d.busy = 1'b0;
      // one command accepted per response
      // Busy drops one cycle later, so takes are two edges apart
      if (cmdValid && !s_q.busy) begin
         s_d.busy = 1'b1;
         s_d.rspValid = 1'b1;
         s_d.rspChan = c;
         s_d.rspStatus = `SW_OK;
         if (!s_q.chan[c].open) begin
            s_d.rspStatus = `SW_NO_CHANNEL;
         end else if (s_q.newerOn && cmdCla == `CLA_LEGACY) begin
            // Checked before decoding, so every command kind is refused
            s_d.rspStatus = `SW_CLA_UNSUPPORTED;
         end else begin
            unique case (cmdKind)
               CMD_SELECT_NAME: begin
                  if (nameLen == 5'h0 || nameLen > `NAME_MAX_LEN) begin
                     s_d.rspStatus = `SW_WRONG_LEN;
                  end else begin
                     if (cmdP1 == `P1_BY_NAME)
                        pick = pickApp(appMatch, cmdP2[1:0], s_q.chan[c].activeApp,
                                       s_q.recency);
                     else
                        pick = pickApp(appMatch, `P2_FIRST, `NO_APP, s_q.recency);
                     if (pick == `NO_APP) begin
                        s_d.rspStatus = `SW_NOT_FOUND;
                     end else if (cmdP2[`P2_CLOSE_BIT]) begin
                        // Close naming another application is answered, not acted on
                        if (pick == s_q.chan[c].activeApp)
                           s_d = endSession(s_d, c);
                     end else if ((appKind == APP_NEWER && (s_q.legacyOn
                           || (s_q.newerOn && s_q.newerApp != pick)))
                           || (appKind == APP_LEGACY && s_q.newerOn)) begin
                        s_d.rspStatus = `SW_NOT_ALLOWED;
                     end else if (s_q.appBusy[pick] && s_q.chan[c].activeApp != pick
                           && !fileShareable) begin
                        s_d.rspStatus = `SW_NOT_ALLOWED;
                     end else begin
                        s_d = endSession(s_d, c);
                        s_d.rspStatus = `SW_OK;
                        s_d.chan[c].activeApp = pick;
                        s_d.appDir[pick] = appDirFid;
                        s_d.appBusy[pick] = 1'b1;
                        s_d.chan[c].curDir = appDirFid;
                        s_d.chan[c].curFile = `NO_FILE;
                        s_d.appStart = 1'b1;
                        // Ranks above the picked one move down, so nonzero ranks stay unique
                        for (int i = 0; i < 16; i++)
                           if (s_q.recency[i] > s_q.recency[pick])
                              s_d.recency[i] = s_q.recency[i] - 4'h1;
                        s_d.recency[pick] = 4'hf;
                        if (appKind == APP_NEWER) begin
                           s_d.newerOn = 1'b1;
                           s_d.newerApp = pick;
                        end
                        if (appKind == APP_LEGACY) begin
                           s_d.legacyOn = 1'b1;
                           s_d.legacyApp = pick;
                        end
                     end
                  end
               end
               CMD_SELECT_FID: begin
                  if (cmdFid == `CURRENT_APP_FID) begin
                     // With no session the special identifier names nothing
                     if (s_q.chan[c].activeApp == `NO_APP) s_d.rspStatus = `SW_NOT_FOUND;
                     else s_d.chan[c].curDir = s_q.appDir[s_q.chan[c].activeApp];
                  end else begin
                     s_d.chan[c].curDir = cmdFid;
                  end
                  s_d.chan[c].curFile = `NO_FILE;
               end
               CMD_SELECT_FILE: begin
                  if (fileIsDir) s_d.chan[c].curDir = cmdFid;
                  else begin
                     s_d.chan[c].curDir = fileParent;
                     s_d.chan[c].curFile = cmdFid;
                     s_d.chan[c].recordPtr = 8'h0;
                  end
                  for (int k = 0; k < `NUM_CHAN; k++)
                     if (k != c && s_q.chan[k].open && !fileShareable
                           && s_q.chan[k].curFile == cmdFid && cmdFid != `NO_FILE)
                        s_d.rspStatus = `SW_NOT_ALLOWED;
                  // A refused selection leaves the channel as it was
                  if (s_d.rspStatus != `SW_OK) s_d.chan[c] = s_q.chan[c];
               end
               CMD_RECORD: s_d.chan[c].recordPtr = recordValue;
               CMD_MANAGE_OPEN: begin
                  // Lowest free number wins; the terminal never picks one
                  for (int k = `NUM_CHAN-1; k > 0; k--)
                     if (!s_q.chan[k].open) begin
                        freeCh = 2'(k);
                        found = 1'b1;
                     end
                  if (!fileShareable) s_d.rspStatus = `SW_NOT_ALLOWED;
                  else if (!found) s_d.rspStatus = `SW_NO_CHANNEL;
                  else begin
                     s_d.chan[freeCh].open = 1'b1;
                     s_d.chan[freeCh].curFile = `NO_FILE;
                     s_d.chan[freeCh].recordPtr = 8'h0;
                     if (c == 2'h0 && cmdCla == `CLA_BASIC) begin
                        s_d.chan[freeCh].curDir = `ROOT_FID;
                        s_d.chan[freeCh].activeApp = `NO_APP;
                     end else begin
                        s_d.chan[freeCh].curDir = s_q.chan[c].curDir;
                        s_d.chan[freeCh].activeApp = s_q.chan[c].activeApp;
                     end
                     s_d.rspChan = freeCh;
                  end
               end
               CMD_MANAGE_CLOSE: begin
                  // Channel 0 cannot be closed
                  if (c == 2'h0) s_d.rspStatus = `SW_NOT_ALLOWED;
                  else begin
                     s_d = endSession(s_d, c);
                     s_d.chan[c].open = 1'b0;
                  end
               end
               default: ;
            endcase
         end
         // Open reports the new channel, everything else the issuing one
         s_d.rspApp = s_d.chan[s_d.rspChan].activeApp;
         s_d.rspDir = s_d.chan[s_d.rspChan].curDir;
         s_d.rspFile = s_d.chan[s_d.rspChan].curFile;
         s_d.rspRecord = s_d.chan[s_d.rspChan].recordPtr;
      end
   end

   // Limitation: reset clears recency too, so last forgets older sessions
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.chan[0].open <= 1'b1;
         for (int k = 0; k < `NUM_CHAN; k++) s_q.chan[k].curDir <= `ROOT_FID;
      end else begin
         s_q <= s_d;
      end
   end

   // Tied low: the busy spacing stands in for a ready handshake
   assign cmdReady = 1'b0;
   assign maxChannels = 4'(`NUM_CHAN - 1);

   // Outputs straight from the state register
   assign rspValid = s_q.rspValid;
   assign rspStatus = s_q.rspStatus;
   assign rspChan = s_q.rspChan;
   assign rspApp = s_q.rspApp;
   assign rspDir = s_q.rspDir;
   assign rspFile = s_q.rspFile;
   assign rspRecord = s_q.rspRecord;
   assign appStart = s_q.appStart;
   assign appStop = s_q.appStop;
endmodule

// file: tb/session_asserts.sv
// Port checks for the session and channel manager
// Bound to the manager from the testbench top file
`timescale 1ns/1ps
`include "app_session_cfg.svh"
module session_asserts
   import app_session_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cmdValid,
   input wire cmd_t cmdKind,
   input wire logic [7:0] cmdCla,
   input wire logic [4:0] nameLen,
   input wire logic fileShareable,
   input wire logic rspValid,
   input wire logic [15:0] rspStatus,
   input wire logic [1:0] rspChan,
   input wire logic [3:0] rspApp,
   input wire logic [15:0] rspDir,
   input wire logic [15:0] rspFile,
   input wire logic appStart,
   input wire logic appStop,
   input wire logic [3:0] maxChannels
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_answer; rspValid |-> $past(cmdValid); endproperty
   property p_pulse; rspValid |=> !rspValid; endproperty
   property p_max; maxChannels == 4'h3; endproperty
   property p_class; rspValid && rspStatus == `SW_CLA_UNSUPPORTED |-> $past(cmdCla) == `CLA_LEGACY;
   endproperty
   property p_opennum; rspValid && $past(cmdKind) == CMD_MANAGE_OPEN && rspStatus == `SW_OK
      |-> rspChan != 2'h0; endproperty
   property p_openbasic; rspValid && $past(cmdKind) == CMD_MANAGE_OPEN && rspStatus == `SW_OK
      && $past(cmdCla) == `CLA_BASIC |-> rspDir == `ROOT_FID && rspFile == `NO_FILE
      && rspApp == `NO_APP; endproperty
   property p_unshared; rspValid && $past(cmdKind) == CMD_MANAGE_OPEN && !$past(fileShareable)
      |-> rspStatus != `SW_OK; endproperty
   property p_len; rspValid && $past(cmdKind) == CMD_SELECT_NAME && $past(nameLen) > 5'h10
      |-> rspStatus != `SW_OK; endproperty
   property p_start; appStart |-> rspValid && rspStatus == `SW_OK; endproperty
   property p_stop; appStop |-> rspValid; endproperty
   a_answer: assert property (p_answer) else $error("answer without command");
   a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
   a_max: assert property (p_max) else $error("channel maximum wrong");
   a_class: assert property (p_class) else $error("class refusal wrong");
   a_opennum: assert property (p_opennum) else $error("open gave channel 0");
   a_openbasic: assert property (p_openbasic) else $error("basic open state wrong");
   a_unshared: assert property (p_unshared) else $error("unshareable open taken");
   a_len: assert property (p_len) else $error("overlong name taken");
   a_start: assert property (p_start) else $error("start without success");
   a_stop: assert property (p_stop) else $error("stop without answer");
   c_start: cover property (appStart);
   c_stop: cover property (appStop);
   c_refuse: cover property (rspValid && rspStatus == `SW_CLA_UNSUPPORTED);
endmodule

// file: tb/terminal_model.sv
// Terminal side: issues one command and holds it until answered or for eight falling edges at most
// File and record inputs other than these stay fixed
`timescale 1ns/1ps
module terminal_model
   import app_session_pkg::*;
(
   input wire logic mclk,
   input wire logic rspValid,
   output logic cmdValid,
   output cmd_t cmdKind,
   output logic [7:0] cmdCla,
   output logic [1:0] cmdChan,
   output logic [7:0] cmdP1,
   output logic [7:0] cmdP2,
   output logic [4:0] nameLen,
   output logic fileShareable,
   output logic [14:0] appMatch,
   output app_kind_t appKind,
   output logic [15:0] appDirFid
);
   initial begin
      {cmdValid, cmdCla, cmdChan, cmdP1, cmdP2, nameLen, fileShareable, appMatch, appDirFid} = '0;
      cmdKind = CMD_OTHER;
      appKind = APP_PLAIN;
   end
   task automatic send(input cmd_t k, input logic [7:0] cla, input logic [1:0] ch,
      input logic [7:0] p1, p2, input logic [4:0] len, input logic [14:0] m,
      input app_kind_t ak, input logic sh, output logic ok);
      ok = 1'b0;
      @(posedge mclk);
      cmdValid <= 1'b1;
      cmdKind <= k;
      cmdCla <= cla;
      cmdChan <= ch;
      cmdP1 <= p1;
      cmdP2 <= p2;
      nameLen <= len;
      appMatch <= m;
      appKind <= ak;
      fileShareable <= sh;
      appDirFid <= 16'h7f00 | {1'b0, m};
      // No second command until this one is answered or eight falling edges pass without an answer
      for (int n = 0; n < 8 && !ok; n++) begin
         @(negedge mclk);
         ok = rspValid;
      end
      @(posedge mclk);
      cmdValid <= 1'b0;
   endtask
endmodule

// file: tb/tb_app_session_channel_manager.sv
// Self-checking bench for the session and channel manager
// Commands go through terminal_model; checker bound at the foot
`timescale 1ns/1ps
`include "app_session_cfg.svh"
module tb_app_session_channel_manager
   import app_session_pkg::*;
;
   logic mclk, rst_n, cmdValid, fileShareable, rspValid, appStart, appStop, ok;
   cmd_t cmdKind;
   app_kind_t appKind;
   logic [7:0] cmdCla, cmdP1, cmdP2, rspRecord;
   logic [1:0] cmdChan, rspChan, ch1;
   logic [4:0] nameLen;
   logic [14:0] appMatch;
   logic [15:0] appDirFid, rspStatus, rspDir, rspFile;
   logic [3:0] rspApp, maxChannels;
   logic startSeen = 1'b0;
   logic stopSeen = 1'b0;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   app_session_channel_manager u_app_session_channel_manager (.mclk, .rst_n, .cmdValid,
      .cmdKind, .cmdCla, .cmdChan, .cmdP1, .cmdP2, .nameLen, .cmdFid(`CURRENT_APP_FID),
      .fileParent(16'h0000), .fileIsDir(1'b1), .fileShareable, .recordValue(8'h5a), .appMatch,
      .appKind, .appDirFid, .cmdReady(), .rspValid, .rspStatus, .rspChan, .rspApp, .rspDir,
      .rspFile, .rspRecord, .appStart, .appStop, .maxChannels);
   terminal_model u_terminal_model (.mclk, .rspValid, .cmdValid, .cmdKind, .cmdCla, .cmdChan,
      .cmdP1, .cmdP2, .nameLen, .fileShareable, .appMatch, .appKind, .appDirFid);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Pulses latched on the falling edge, clear of the edge that launches them
   always @(negedge mclk) begin
      cycles <= cycles + 1;
      if (rspValid) begin
         startSeen <= appStart;
         stopSeen <= appStop;
      end
      if (cycles == 2000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input cmd_t k, input logic [7:0] cla, input logic [1:0] ch,
      input logic [7:0] p1, p2, input logic [4:0] len, input logic [14:0] m,
      input app_kind_t ak, input logic sh);
      u_terminal_model.send(k, cla, ch, p1, p2, len, m, ak, sh, ok);
      @(negedge mclk);
      chk("answer", 16'h0001, {15'h0, ok});
   endtask
   task automatic t_open_basic();
      cmd(CMD_MANAGE_OPEN, 8'h00, 2'h0, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b1);
      ch1 = rspChan;
      chk("open status", `SW_OK, rspStatus);
      chk("open channel", 16'h0001, {15'h0, ch1 != 2'h0});
      chk("open dir", `ROOT_FID, rspDir);
      chk("open app", 16'h0000, {12'h0, rspApp});
      chk("open file", `NO_FILE, rspFile);
   endtask
   task automatic t_partial();
      for (int i = 0; i < 4; i++) begin
         // Matches are 2 and 5: first, last (most recent), next, previous
         cmd(CMD_SELECT_NAME, 8'h00, 2'h0, `P1_BY_NAME, {6'h0, i[1:0]}, 5'h03, 15'h0012,
            APP_PLAIN, 1'b1);
         chk("pick status", `SW_OK, rspStatus);
         chk("pick app", (i == 2) ? 16'h0005 : 16'h0002, {12'h0, rspApp});
         chk("pick start", 16'h0001, {15'h0, startSeen});
      end
   endtask
   task automatic t_newer();
      // Parallel session needs its own channel
      cmd(CMD_SELECT_NAME, 8'h01, ch1, 8'h00, 8'h00, 5'h10, 15'h0001, APP_NEWER, 1'b1);
      chk("newer status", `SW_OK, rspStatus);
      chk("newer start", 16'h0001, {15'h0, startSeen});
      cmd(CMD_SELECT_FID, 8'h01, ch1, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b1);
      chk("current app dir", 16'h7f01, rspDir);
      cmd(CMD_RECORD, 8'h01, ch1, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b1);
      chk("record", 16'h005a, {8'h0, rspRecord});
      cmd(CMD_OTHER, `CLA_LEGACY, 2'h0, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b1);
      chk("legacy class", `SW_CLA_UNSUPPORTED, rspStatus);
      cmd(CMD_SELECT_NAME, 8'h00, 2'h0, 8'h00, 8'h00, 5'h04, 15'h0004, APP_LEGACY, 1'b1);
      chk("legacy start", 16'h0000, {15'h0, startSeen});
      cmd(CMD_SELECT_NAME, 8'h00, 2'h0, 8'h00, 8'h00, 5'h04, 15'h0020, APP_NEWER, 1'b1);
      chk("second newer", 16'h0000, {15'h0, startSeen});
   endtask
   task automatic t_channels();
      cmd(CMD_MANAGE_OPEN, 8'h01, ch1, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b1);
      chk("inherit app", 16'h0001, {12'h0, rspApp});
      chk("inherit dir", 16'h7f01, rspDir);
      chk("inherit file", `NO_FILE, rspFile);
      chk("inherit record", 16'h0000, {8'h0, rspRecord});
      cmd(CMD_MANAGE_OPEN, 8'h00, 2'h0, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b0);
      chk("unshared", `SW_NOT_ALLOWED, rspStatus);
      cmd(CMD_MANAGE_OPEN, 8'h00, 2'h0, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b1);
      chk("third open", `SW_OK, rspStatus);
      cmd(CMD_MANAGE_OPEN, 8'h00, 2'h0, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b1);
      chk("fourth open", `SW_NO_CHANNEL, rspStatus);
      cmd(CMD_MANAGE_CLOSE, 8'h01, ch1, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b1);
      chk("close status", `SW_OK, rspStatus);
      chk("close stop", 16'h0001, {15'h0, stopSeen});
   endtask
   task automatic t_end();
      cmd(CMD_SELECT_NAME, 8'h00, 2'h0, `P1_BY_NAME, 8'h40, 5'h03, 15'h0002, APP_PLAIN, 1'b1);
      chk("close option", 16'h0001, {15'h0, stopSeen});
      chk("app cleared", 16'h0000, {12'h0, rspApp});
      cmd(CMD_SELECT_NAME, 8'h00, 2'h0, 8'h00, 8'h00, 5'h11, 15'h0010, APP_PLAIN, 1'b1);
      chk("long name", 16'h0000, {15'h0, rspStatus == `SW_OK});
      // Short reset in mid-run; one newer session still open on channel 2 before it
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      cmd(CMD_OTHER, `CLA_LEGACY, 2'h0, 8'h00, 8'h00, 5'h00, 15'h0, APP_PLAIN, 1'b1);
      chk("after reset", 16'h0000, {15'h0, rspStatus == `SW_CLA_UNSUPPORTED});
      chk("max channels", 16'h0003, {12'h0, maxChannels});
   endtask
   task automatic finish_test();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      t_open_basic();
      t_partial();
      t_newer();
      t_channels();
      t_end();
      finish_test();
   end
endmodule
bind app_session_channel_manager session_asserts u_session_asserts (.mclk, .rst_n, .cmdValid,
   .cmdKind, .cmdCla, .nameLen, .fileShareable, .rspValid, .rspStatus, .rspChan, .rspApp,
   .rspDir, .rspFile, .appStart, .appStop, .maxChannels);
